// File: core/uvc_pkg.sv
// package: constants and types for the vendor command interpreter
package uvc_pkg;
	localparam logic [7:0] REQ_TYPE_OUT = 8'h40;
	localparam logic [7:0] REQ_TYPE_IN = 8'hC0;
	localparam logic [7:0] REQ_REG_WRITE = 8'hA0;
	localparam logic [7:0] REQ_REG_READ = 8'hA1;
	localparam logic [7:0] REQ_MEM_READ = 8'hA2;
	localparam logic [7:0] REQ_STATS = 8'hA3;
	localparam logic [15:0] REG_LEN = 16'h0004;
	localparam logic [15:0] STATS_LEN = 16'h002C;
	localparam logic [15:0] HDMI_BASE = 16'h9000;
	localparam logic [15:0] HDMI_LIMIT = 16'h9800;
	localparam logic [5:0] BLOCK_BYTES = 6'h3F;
	localparam int NUM_CNT = 11;
	localparam logic [4:0] LTSSM_U0 = 5'h0C;
	localparam logic [4:0] LTSSM_RECOVERY = 5'h11;
	localparam logic [2:0] RXS_DECODE = 3'h4;
	localparam logic [2:0] RXS_EB_OVER = 3'h5;
	localparam logic [2:0] RXS_EB_UNDER = 3'h6;
	localparam logic [2:0] RXS_DISPARITY = 3'h7;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WR_DATA,
		ST_WR_ISSUE,
		ST_RD_WAIT,
		ST_MEM,
		ST_TX
	} uvc_state_t;
endpackage : uvc_pkg

// File: core/uvc_vendor_cmd.sv
// vendor control command interpreter with rolling statistics counters
// Overview of operation
// - write request is type 40h, code A0h, value 0, index address, length 4
// - each register write moves exactly one 32-bit word from the data stage
// - HDMI byte registers sit at 9000h plus four times their address
// - HDMI window writes keep only data bits 7:0
// - read request is type C0h, code A1h, value 0, length 4, one word
// - memory read is C0h/A2h, value address 15:0, index address 24:16
// - low three memory address bits are ignored
// - memory length rounds up to a whole 64-byte block
// - statistics is C0h/A3h, value and index 0, length 2Ch
// - counters are snapshot on request, cleared only by reset, and wrap
// - counter 00h counts good bulk-out data packets including zero length
// - counter 04h counts good vendor control data packets received
// - counter 08h counts good vendor control data packets sent
// - counter 0Ch counts errored vendor setups in SuperSpeed only
// - counter 10h counts errored control data received in SuperSpeed
// - counter 14h counts failed control data sends in SuperSpeed
// - counter 18h counts errored bulk-out packets passed up, SuperSpeed
// - counter 1Ch counts receive status 100 or 111 in SuperSpeed
// - counters 20h and 24h count receive status 101 and 110
// - counter 28h counts link state changes from U0 to Recovery
// - SuperSpeed-only counters read zero in USB 2.0 mode
module uvc_vendor_cmd (
	input wire logic sys_clk, // controller clock
	input wire logic resetn, // synchronous reset, active low
	input wire logic setupValid, // one-cycle setup packet strobe
	input wire logic [7:0] setupType, // request type byte
	input wire logic [7:0] setupCode, // request code byte
	input wire logic [15:0] setupValue, // value field
	input wire logic [15:0] setupIndex, // index field
	input wire logic [15:0] setupLength, // length field
	input wire logic rxDataValid, // control out data byte strobe
	input wire logic [7:0] rxData, // control out data byte
	output logic txDataValid, // control in data byte strobe
	output logic [7:0] txData, // control in data byte
	input wire logic txDataReady, // controller takes the byte
	output logic cmdAck, // setup decoded as a vendor command
	output logic cmdStall, // vendor setup not understood
	output logic csrWrite, // one-cycle register write strobe
	output logic csrRead, // one-cycle register read strobe
	output logic [15:0] csrAddr, // register address
	output logic [31:0] csrWdata, // register write data
	input wire logic csrRvalid, // read data valid pulse
	input wire logic [31:0] csrRdata, // read data
	output logic memReq, // memory word request level
	output logic [24:0] memAddr, // memory byte address, quad-word aligned
	input wire logic memValid, // memory quad-word valid pulse
	input wire logic [63:0] memData, // memory quad-word
	input wire logic superSpeed, // link runs in SuperSpeed
	input wire logic evBulkRxOk, // good bulk-out data packet
	input wire logic evCtlRxOk, // good control data packet received
	input wire logic evCtlTxOk, // good control data packet sent
	input wire logic evSetupErr, // errored vendor setup, not a retry
	input wire logic evCtlRxErr, // errored control data, not a retry
	input wire logic evCtlTxErr, // failed control data send
	input wire logic evBulkRxErr, // errored bulk-out passed up
	input wire logic [2:0] pipeRxStatus, // PIPE receive status
	input wire logic [4:0] ltssmState // link training state
);
	uvc_pkg::uvc_state_t state_q, state_d;
	logic [31:0] cnt_q [uvc_pkg::NUM_CNT];
	logic [31:0] snap_q [uvc_pkg::NUM_CNT];
	logic [4:0] ltssmPrev_q;
	logic vendorCtl_q;
	logic [31:0] word_q;
	logic [63:0] quad_q;
	logic [15:0] remain_q;
	logic [2:0] byteIdx_q;
	logic [3:0] wordIdx_q;
	logic isStats_q;
	logic isMem_q;

	// ----------------------------------------
	// setup decode
	// ----------------------------------------
	wire isWr = setupType == uvc_pkg::REQ_TYPE_OUT
		&& setupCode == uvc_pkg::REQ_REG_WRITE && setupValue == 16'h0000
		&& setupLength == uvc_pkg::REG_LEN;
	wire isRd = setupType == uvc_pkg::REQ_TYPE_IN
		&& setupCode == uvc_pkg::REQ_REG_READ && setupValue == 16'h0000
		&& setupLength == uvc_pkg::REG_LEN;
	wire isMemRd = setupType == uvc_pkg::REQ_TYPE_IN
		&& setupCode == uvc_pkg::REQ_MEM_READ
		&& setupIndex[15:9] == 7'h00;
	wire isSt = setupType == uvc_pkg::REQ_TYPE_IN
		&& setupCode == uvc_pkg::REQ_STATS && setupValue == 16'h0000
		&& setupIndex == 16'h0000
		&& setupLength == uvc_pkg::STATS_LEN;
	wire isVendor = setupType[6:5] == 2'b10;
	wire setupTake = setupValid && state_q == uvc_pkg::ST_IDLE;
	wire anyCmd = isWr || isRd || isMemRd || isSt;
	// round the length up to a whole block
	wire [16:0] memLen = {1'b0, setupLength[15:6], 6'h00}
		+ {10'h000, |(setupLength[5:0] & uvc_pkg::BLOCK_BYTES), 6'h00};
	wire inHdmi = csrAddr >= uvc_pkg::HDMI_BASE
		&& csrAddr < uvc_pkg::HDMI_LIMIT;
	// upper bytes of a transmitter write are dropped as they arrive, so the
	// target never sees them beside the strobe
	wire [7:0] wrByte = (inHdmi && byteIdx_q[1:0] != 2'h0) ? 8'h00
		: rxData;
	wire txTake = txDataValid && txDataReady;
	wire lastByte = txTake && remain_q == 16'h0001;
	wire memNeed = isMem_q && byteIdx_q == 3'h7 && txTake && !lastByte;

	// ----------------------------------------
	// statistics events
	// ----------------------------------------
	wire [uvc_pkg::NUM_CNT-1:0] evInc;
	assign evInc[0] = evBulkRxOk;
	assign evInc[1] = evCtlRxOk && vendorCtl_q;
	assign evInc[2] = evCtlTxOk && vendorCtl_q;
	assign evInc[3] = superSpeed && evSetupErr;
	assign evInc[4] = superSpeed && evCtlRxErr;
	assign evInc[5] = superSpeed && evCtlTxErr;
	assign evInc[6] = superSpeed && evBulkRxErr;
	assign evInc[7] = superSpeed && (pipeRxStatus == uvc_pkg::RXS_DECODE
		|| pipeRxStatus == uvc_pkg::RXS_DISPARITY);
	assign evInc[8] = superSpeed
		&& pipeRxStatus == uvc_pkg::RXS_EB_OVER;
	assign evInc[9] = superSpeed
		&& pipeRxStatus == uvc_pkg::RXS_EB_UNDER;
	assign evInc[10] = superSpeed && ltssmPrev_q == uvc_pkg::LTSSM_U0
		&& ltssmState == uvc_pkg::LTSSM_RECOVERY;

	genvar gi;
	generate
		for (gi = 0; gi < uvc_pkg::NUM_CNT; gi++) begin : g_cnt
			// counters only roll over; reading never clears them
			always_ff @(posedge sys_clk) begin
				if (!resetn)
					cnt_q[gi] <= 32'h0000_0000;
				else if (evInc[gi])
					cnt_q[gi] <= cnt_q[gi] + 32'h0000_0001;
			end
			always_ff @(posedge sys_clk) begin
				if (!resetn)
					snap_q[gi] <= 32'h0000_0000;
				else if (setupTake && isSt)
					snap_q[gi] <= (gi >= 3 && !superSpeed) ? 32'h0000_0000
						: cnt_q[gi];
			end
		end
	endgenerate

	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			uvc_pkg::ST_IDLE: begin
				if (setupTake && isWr)
					state_d = uvc_pkg::ST_WR_DATA;
				else if (setupTake && isRd)
					state_d = uvc_pkg::ST_RD_WAIT;
				else if (setupTake && isMemRd && memLen != 17'h00000)
					state_d = uvc_pkg::ST_MEM;
				else if (setupTake && isSt)
					state_d = uvc_pkg::ST_TX;
			end
			uvc_pkg::ST_WR_DATA:
				if (rxDataValid && byteIdx_q == 3'h3)
					state_d = uvc_pkg::ST_WR_ISSUE;
			uvc_pkg::ST_WR_ISSUE: state_d = uvc_pkg::ST_IDLE;
			uvc_pkg::ST_RD_WAIT:
				if (csrRvalid)
					state_d = uvc_pkg::ST_TX;
			uvc_pkg::ST_MEM:
				if (memValid)
					state_d = uvc_pkg::ST_TX;
			uvc_pkg::ST_TX: begin
				if (lastByte)
					state_d = uvc_pkg::ST_IDLE;
				else if (memNeed)
					state_d = uvc_pkg::ST_MEM;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn)
			state_q <= uvc_pkg::ST_IDLE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cmdAck <= 1'b0;
			cmdStall <= 1'b0;
			vendorCtl_q <= 1'b0;
		end else begin
			cmdAck <= setupTake && isVendor && anyCmd;
			cmdStall <= setupTake && isVendor && !anyCmd;
			if (setupValid)
				vendorCtl_q <= isVendor && anyCmd;
		end
	end

	// register access: address, data gathered little-endian, strobes
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			csrAddr <= 16'h0000;
			csrWdata <= 32'h0000_0000;
			csrWrite <= 1'b0;
			csrRead <= 1'b0;
		end else begin
			if (setupTake && (isWr || isRd))
				csrAddr <= setupIndex;
			if (state_q == uvc_pkg::ST_WR_DATA && rxDataValid)
				csrWdata[byteIdx_q[1:0]*8 +: 8] <= wrByte;
			else if (state_q == uvc_pkg::ST_WR_ISSUE && inHdmi)
				csrWdata <= {24'h000000, csrWdata[7:0]};
			csrWrite <= state_q == uvc_pkg::ST_WR_DATA && rxDataValid
				&& byteIdx_q == 3'h3;
			csrRead <= setupTake && isRd;
		end
	end

	// ----------------------------------------
	// in data stage
	// ----------------------------------------
	wire [7:0] statByte = snap_q[wordIdx_q][byteIdx_q[1:0]*8 +: 8];
	wire [7:0] nextByte = isMem_q ? quad_q[byteIdx_q*8 +: 8]
		: isStats_q ? statByte : word_q[byteIdx_q[1:0]*8 +: 8];

	// byte following the one being handed over this cycle
	logic [2:0] byteNx;
	logic [3:0] wordNx;
	logic [7:0] nextByteAfter;
	assign byteNx = byteIdx_q + 3'h1;
	assign wordNx = byteIdx_q[1:0] == 2'h3 ? wordIdx_q + 4'h1 : wordIdx_q;
	assign nextByteAfter = isMem_q ? quad_q[byteNx*8 +: 8]
		: isStats_q ? snap_q[wordNx][byteNx[1:0]*8 +: 8]
		: word_q[byteNx[1:0]*8 +: 8];

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			byteIdx_q <= 3'h0;
			wordIdx_q <= 4'h0;
			remain_q <= 16'h0000;
			isStats_q <= 1'b0;
			isMem_q <= 1'b0;
			word_q <= 32'h0000_0000;
			quad_q <= 64'h0;
			memAddr <= 25'h0000000;
			memReq <= 1'b0;
		end else begin
			if (setupTake) begin
				byteIdx_q <= 3'h0;
				wordIdx_q <= 4'h0;
				isStats_q <= isSt;
				isMem_q <= isMemRd;
				remain_q <= isSt ? uvc_pkg::STATS_LEN
					: isMemRd ? memLen[15:0] : uvc_pkg::REG_LEN;
				memAddr <= {setupIndex[8:0], setupValue[15:3], 3'h0};
				memReq <= isMemRd && memLen != 17'h00000;
			end else if (state_q == uvc_pkg::ST_WR_DATA && rxDataValid) begin
				byteIdx_q <= byteIdx_q + 3'h1;
			end else if (state_q == uvc_pkg::ST_WR_ISSUE) begin
				byteIdx_q <= 3'h0;
			end else if (state_q == uvc_pkg::ST_MEM && memValid) begin
				quad_q <= memData;
				memReq <= 1'b0;
				memAddr <= memAddr + 25'h0000008;
			end else if (memNeed) begin
				memReq <= 1'b1;
				byteIdx_q <= 3'h0;
				remain_q <= remain_q - 16'h0001;
			end else if (txTake) begin
				remain_q <= remain_q - 16'h0001;
				byteIdx_q <= byteIdx_q + 3'h1;
				if (byteIdx_q[1:0] == 2'h3)
					wordIdx_q <= wordIdx_q + 4'h1;
			end
			if (state_q == uvc_pkg::ST_RD_WAIT && csrRvalid)
				word_q <= csrRdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			txDataValid <= 1'b0;
			txData <= 8'h00;
		end else begin
			// a fresh byte is loaded only when the previous one was taken
			if (state_q == uvc_pkg::ST_TX && (!txDataValid || txTake)
				&& !lastByte && !memNeed) begin
				txDataValid <= 1'b1;
				txData <= txTake ? nextByteAfter : nextByte;
			end else if (txTake || state_q != uvc_pkg::ST_TX) begin
				txDataValid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// link state history
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!resetn)
			ltssmPrev_q <= 5'h00;
		else
			ltssmPrev_q <= ltssmState;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_write_strobe: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		state_q == uvc_pkg::ST_WR_DATA && rxDataValid && byteIdx_q == 3'h3
		|=> csrWrite) else $error("write strobe missing");
	a_read_strobe: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		setupTake && isRd |=> csrRead && csrAddr == $past(setupIndex))
		else $error("read strobe missing");
	a_hdmi_mask: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		csrWrite && inHdmi |-> csrWdata[31:8] == 24'h000000)
		else $error("hdmi upper bits kept");
	a_mem_align: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		memReq |-> memAddr[2:0] == 3'h0) else $error("memory unaligned");
	a_mem_length: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		setupTake && isMemRd |=> remain_q[5:0] == 6'h00)
		else $error("memory length not whole blocks");
	a_stats_length: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		setupTake && isSt |=> remain_q == uvc_pkg::STATS_LEN)
		else $error("statistics length wrong");
	a_ss_zero: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		setupTake && isSt && !superSpeed |=> snap_q[7] == 32'h0)
		else $error("usb2 counter not zero");
	a_cnt_wrap: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		evInc[0] |=> cnt_q[0] == $past(cnt_q[0]) + 32'h1)
		else $error("bulk counter did not step");
	a_recovery_cnt: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		superSpeed && ltssmPrev_q == uvc_pkg::LTSSM_U0
		&& ltssmState == uvc_pkg::LTSSM_RECOVERY
		|=> cnt_q[10] != $past(cnt_q[10])) else $error("recovery missed");
	a_vendor_stall: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		setupTake && isVendor && !anyCmd |=> cmdStall && !cmdAck)
		else $error("unknown vendor setup not stalled");
	a_tx_hold: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		txDataValid && !txDataReady |=> txDataValid && $stable(txData))
		else $error("data byte dropped while host stalls");
endmodule : uvc_vendor_cmd

// File: tb/uvc_far_model.sv
// register target and memory model on the far side of the interpreter
module uvc_far_model (
	input wire logic sys_clk, // controller clock
	input wire logic csrRead, // register read strobe
	input wire logic [15:0] csrAddr, // register address
	output logic csrRvalid, // read data valid pulse
	output logic [31:0] csrRdata, // read data
	input wire logic memReq, // memory word request
	input wire logic [24:0] memAddr, // memory byte address
	output logic memValid, // quad-word valid pulse
	output logic [63:0] memData // quad-word, byte0 low
);
	timeunit 1ns;
	timeprecision 1ps;
	int rc = 0;
	int mc = 0;
	initial begin
		csrRvalid = 0;
		csrRdata = 32'h0;
		memValid = 0;
		memData = 64'h0;
	end
	// read data is {~addr, addr}; outside the pulse the bus inverts every cycle
	always @(posedge sys_clk) begin
		csrRvalid <= (rc == 1);
		if (rc == 1) begin
			csrRdata <= {~csrAddr, csrAddr};
		end else begin
			csrRdata <= ~csrRdata;
		end
		if (csrRead) begin
			rc <= 3;
		end else if (rc > 0) begin
			rc <= rc - 1;
		end
	end
	// each memory byte holds the low byte of its own address
	always @(posedge sys_clk) begin
		if (memValid) begin
			memValid <= 0;
			memData <= ~memData;
		end else if (mc == 1) begin
			memValid <= 1;
			for (int i = 0; i < 8; i++) begin
				memData[8*i+:8] <= 8'(memAddr + 25'(i));
			end
			mc <= 0;
		end else if (mc > 1) begin
			mc <= mc - 1;
		end else if (memReq) begin
			mc <= 2;
		end
	end
endmodule : uvc_far_model

// File: tb/usb_vendor_cmd_stats_bench.sv
// self-checking bench for the vendor command interpreter
module usb_vendor_cmd_stats_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, resetn = 0, setupValid = 0, rxDataValid = 0;
	logic txDataReady = 1, superSpeed = 1;
	logic slowRdy = 0;
	logic [7:0] setupType = 8'h00, setupCode = 8'h00, rxData = 8'h00;
	logic [15:0] setupValue = 16'h0, setupIndex = 16'h0, setupLength = 16'h0;
	logic [6:0] ev = 7'h00;
	logic [2:0] pipeRxStatus = 3'h0;
	logic [4:0] ltssmState = 5'h00;
	logic txDataValid, cmdAck, cmdStall, csrWrite, csrRead, csrRvalid;
	logic memReq, memValid;
	logic [7:0] txData;
	logic [15:0] csrAddr;
	logic [31:0] csrWdata, csrRdata;
	logic [24:0] memAddr;
	logic [63:0] memData;
	logic [7:0] rx[$];
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	always #4 sys_clk = ~sys_clk;
	// a slow host refuses one byte in three
	always @(posedge sys_clk) #1 txDataReady = !(slowRdy && cyc % 3 == 0);
	uvc_vendor_cmd dut_u (.sys_clk(sys_clk), .resetn(resetn),
		.setupValid(setupValid), .setupType(setupType),
		.setupCode(setupCode), .setupValue(setupValue),
		.setupIndex(setupIndex), .setupLength(setupLength),
		.rxDataValid(rxDataValid), .rxData(rxData),
		.txDataValid(txDataValid), .txData(txData),
		.txDataReady(txDataReady), .cmdAck(cmdAck), .cmdStall(cmdStall),
		.csrWrite(csrWrite), .csrRead(csrRead), .csrAddr(csrAddr),
		.csrWdata(csrWdata), .csrRvalid(csrRvalid), .csrRdata(csrRdata),
		.memReq(memReq), .memAddr(memAddr), .memValid(memValid),
		.memData(memData), .superSpeed(superSpeed), .evBulkRxOk(ev[0]),
		.evCtlRxOk(ev[1]), .evCtlTxOk(ev[2]), .evSetupErr(ev[3]),
		.evCtlRxErr(ev[4]), .evCtlTxErr(ev[5]), .evBulkRxErr(ev[6]),
		.pipeRxStatus(pipeRxStatus), .ltssmState(ltssmState));
	uvc_far_model far_u (.sys_clk(sys_clk), .csrRead(csrRead),
		.csrAddr(csrAddr), .csrRvalid(csrRvalid), .csrRdata(csrRdata),
		.memReq(memReq), .memAddr(memAddr), .memValid(memValid),
		.memData(memData));
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic setup(logic [7:0] t, logic [7:0] c, logic [15:0] v,
		logic [15:0] i, logic [15:0] l, logic ok = 1'b1);
		@(posedge sys_clk) #1;
		{setupType, setupCode, setupValue, setupIndex} = {t, c, v, i};
		setupLength = l;
		setupValid = 1;
		@(posedge sys_clk) #1;
		setupValid = 0;
		chk("cmd ack", 32'(ok), 32'(cmdAck));
		chk("cmd stall", 32'(!ok), 32'(cmdStall));
	endtask : setup
	// gathers bytes until the data stage has been quiet for 50 cycles
	task automatic getb();
		int q;
		q = 0;
		rx.delete();
		while (q < 50) begin
			@(negedge sys_clk);
			q++;
			if (txDataValid === 1'b1 && txDataReady === 1'b1) begin
				rx.push_back(txData);
				q = 0;
			end
		end
	endtask : getb
	function automatic logic [31:0] w(int k);
		return {rx[k+3], rx[k+2], rx[k+1], rx[k]};
	endfunction : w
	task automatic wr(logic [15:0] a, logic [31:0] d, logic [31:0] e);
		int g;
		setup(uvc_pkg::REQ_TYPE_OUT, uvc_pkg::REQ_REG_WRITE, 16'h0, a, 16'h4);
		for (int i = 0; i < 4; i++) begin
			rxDataValid = 1;
			rxData = d[8*i+:8];
			@(posedge sys_clk) #1;
		end
		rxDataValid = 0;
		g = 0;
		while (csrWrite !== 1'b1 && g < 100) begin
			@(negedge sys_clk);
			g++;
		end
		chk("wr addr", 32'(a), 32'(csrAddr));
		chk("wr data at strobe", e, csrWdata);
		@(posedge sys_clk) #1;
		chk("wr strobe width", 32'h0, 32'(csrWrite));
		chk("wr data", e, csrWdata);
		$display("test write %h done", a);
	endtask : wr
	task automatic rd(logic [15:0] a, logic [31:0] m);
		setup(uvc_pkg::REQ_TYPE_IN, uvc_pkg::REQ_REG_READ, 16'h0, a, 16'h4);
		getb();
		chk("rd count", 32'd4, 32'(rx.size()));
		// the host keeps only the low byte of a transmitter register
		chk("rd data", {~a, a} & m, w(0) & m);
		$display("test read %h done", a);
	endtask : rd
	task automatic mem();
		setup(uvc_pkg::REQ_TYPE_IN, uvc_pkg::REQ_MEM_READ, 16'h1235,
			16'h0001, 16'h0041);
		getb();
		chk("mem count", 32'd128, 32'(rx.size()));
		for (int i = 0; i < rx.size(); i++) begin
			chk("mem byte", 32'(8'(32'h11230 + i)), 32'(rx[i]));
		end
		$display("test memory read done");
	endtask : mem
	task automatic stall();
		// a write setup with a nonzero value field is no command
		setup(uvc_pkg::REQ_TYPE_OUT, uvc_pkg::REQ_REG_WRITE, 16'h0001,
			16'h1234, 16'h4, 1'b0);
		repeat (6) @(posedge sys_clk);
		#1;
		chk("stall write", 32'h0, 32'(csrWrite));
		$display("test stall done");
	endtask : stall
	task automatic stats(logic [31:0] lo, logic [31:0] hi, logic [31:0] pv);
		setup(uvc_pkg::REQ_TYPE_IN, uvc_pkg::REQ_STATS, 16'h0, 16'h0,
			uvc_pkg::STATS_LEN);
		getb();
		chk("stats count", 32'd44, 32'(rx.size()));
		for (int k = 0; k < 3; k++) begin
			chk("good counter", lo, w(4*k));
		end
		for (int k = 3; k < 7; k++) begin
			chk("error counter", hi, w(4*k));
		end
		chk("decode counter", hi, w(28));
		chk("overflow counter", pv, w(32));
		chk("underflow counter", pv, w(36));
		chk("recovery counter", pv, w(40));
		$display("test statistics done");
	endtask : stats
	task automatic events();
		logic [2:0] s[5] = '{3'h4, 3'h7, 3'h5, 3'h6, 3'h0};
		logic [4:0] l[4] = '{5'h0C, 5'h11, 5'h0C, 5'h00};
		for (int i = 0; i < 5; i++) begin
			ev = (i < 2) ? 7'h7F : 7'h00;
			pipeRxStatus = s[i];
			ltssmState = l[i%4];
			@(posedge sys_clk) #1;
		end
	endtask : events
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		#1 resetn = 1;
		wr(16'h1234, 32'hA1B2C3D4, 32'hA1B2C3D4);
		wr(uvc_pkg::HDMI_BASE + 16'h0014, 32'h12345678, 32'h00000078);
		stall();
		rd(16'h0340, 32'hFFFFFFFF);
		rd(uvc_pkg::HDMI_BASE + 16'h0014, 32'h000000FF);
		mem();
		events();
		stats(32'd2, 32'd2, 32'd1);
		@(posedge sys_clk) #1;
		superSpeed = 0;
		// the second snapshot is read out against a stalling host
		slowRdy = 1;
		ev = 7'h07;
		@(posedge sys_clk) #1;
		ev = 7'h00;
		stats(32'd3, 32'd0, 32'd0);
		end_sim();
	end
endmodule : usb_vendor_cmd_stats_bench
